// ===== rtl/tpm_pkg.sv
// constants and types shared by the timer pwm block
package tpm_pkg;

    // ------------------------------------------------------------------
    // widths and count limits
    // ------------------------------------------------------------------
    localparam int         CNT_W       = 8;      // every counter half is one byte
    localparam logic [7:0] CNT_MAX     = 8'hFF;  // last count before the wrap
    localparam logic [7:0] CNT_ZERO    = 8'h00;  // wrap value, starts each pwm period
    localparam logic [7:0] CNT_ONE     = 8'h01;  // count step

    // ------------------------------------------------------------------
    // timer_control_b layout and reset value
    // ------------------------------------------------------------------
    localparam logic [7:0] TCB_RESET    = 8'h24;  // both prescale_sel fields at 100B
    localparam int         TCB_PWM1_BIT = 7;      // pwm1_enable
    localparam int         TCB_PWM0_BIT = 6;      // pwm0_enable
    localparam int         TCB_PSC1_LSB = 3;      // prescale_sel of timer 1, 3 bits
    localparam int         TCB_PSC0_LSB = 0;      // prescale_sel of timer 0, 3 bits
    localparam int         PSC_W        = 3;      // prescale_sel width

    // ------------------------------------------------------------------
    // timer_mode_reg layout
    // ------------------------------------------------------------------
    localparam int         TIMER_MODE_REG_GATE1_BIT = 7;    // gate of timer 1
    localparam int         TIMER_MODE_REG_CT1_BIT   = 6;    // counter_timer_select of timer 1
    localparam int         TIMER_MODE_REG_M1_LSB    = 4;    // mode bits of timer 1
    localparam int         TIMER_MODE_REG_GATE0_BIT = 3;    // gate of timer 0
    localparam int         TIMER_MODE_REG_CT0_BIT   = 2;    // counter_timer_select of timer 0
    localparam int         TIMER_MODE_REG_M0_LSB    = 0;    // mode bits of timer 0

    // ------------------------------------------------------------------
    // sub-mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_0 = 2'h0;  // log prescaler
    localparam logic [1:0] MODE_1 = 2'h1;  // linear prescaler / 16-bit reload
    localparam logic [1:0] MODE_2 = 2'h2;  // 8-bit auto reload, frequency generator
    localparam logic [1:0] MODE_3 = 2'h3;  // split / stopped

    // state of one timer
    typedef struct packed {
        logic [7:0] low;   // low_count
        logic [7:0] high;  // high_count
        logic [7:0] ocr;   // active_compare
        logic       pin;   // waveform level before pin gating
        logic       ovf;   // overflow event of the last step
    } tpm_timer_t;

endpackage

// ===== rtl/tpm_timer_pwm.sv
// pwm extension of two 8-bit/16-bit timers: counters, compare outputs, flags
`timescale 1ns/10ps
module tpm_timer_pwm
    import tpm_pkg::*;
#(
    parameter int TPS_W = 4                           // width of timer_prescaler
) (
    input  wire logic             ref_clk_i,          // 20 MHz system clock
    input  wire logic             reset_n_i,          // synchronous, active low
    input  wire logic [7:0]       timer_mode_reg_i,   // gate, c/t and mode bits
    input  wire logic             timer_control_b_we_i,    // write strobe
    input  wire logic [7:0]       timer_control_b_wdata_i, // write data
    input  wire logic [TPS_W-1:0] timer_prescaler_i,  // shared divider value
    input  wire logic             run0_i,             // timer 0 run bit
    input  wire logic             run1_i,             // timer 1 run bit
    input  wire logic             ext_irq0_pin_i,     // gate input of timer 0
    input  wire logic             ext_irq1_pin_i,     // gate input of timer 1
    input  wire logic [7:0]       low_reload0_i,      // timer 0 low reload
    input  wire logic [7:0]       low_reload1_i,      // timer 1 low reload
    input  wire logic [7:0]       compare_hold0_i,    // timer 0 duty hold
    input  wire logic [7:0]       compare_hold1_i,    // timer 1 duty hold
    input  wire logic             overflow0_clr_i,    // clears overflow0
    input  wire logic             overflow1_clr_i,    // clears overflow1
    output logic                  timer0_pin_o,       // waveform on timer0_pin
    output logic                  timer0_pin_oe_o,    // high while pwm drives the pin
    output logic                  timer1_pin_o,       // waveform on timer1_pin
    output logic                  timer1_pin_oe_o,    // high while pwm drives the pin
    output logic                  overflow0_o,        // sticky overflow flag
    output logic                  overflow1_o,        // sticky overflow flag
    output logic                  baud_tick_o,        // one-cycle timer 1 overflow
    output logic [7:0]            timer_control_b_o,  // readback of timer_control_b
    output logic [7:0]            low_count0_o,       // counter state
    output logic [7:0]            high_count0_o,      // counter state
    output logic [7:0]            low_count1_o,       // counter state
    output logic [7:0]            high_count1_o       // counter state
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // the whole block state lives in one packed struct
    typedef struct packed {
        logic [7:0] tcb;      // timer_control_b
        logic [7:0] timer_prescaler;      // shared prescaler count
        tpm_timer_t t0;       // timer 0
        tpm_timer_t t1;       // timer 1
        logic [7:0] ocr_lo;   // active_compare of the split low channel
        logic       pin_lo;   // split low channel waveform
        logic       pin_hi;   // split high channel waveform
        logic       out0;     // gated pin 0 level
        logic       out1;     // gated pin 1 level
        logic       oe0;      // pin 0 enable
        logic       oe1;      // pin 1 enable
        logic       ovf0;     // overflow0 flag
        logic       ovf1;     // overflow1 flag
        logic       baud;     // baud tick pulse
    } tpm_state_t;

    tpm_state_t r;       // registered state
    tpm_state_t next_r;  // next state

    // ------------------------------------------------------------------
    // one timer step outside the split mode
    // ------------------------------------------------------------------
    function automatic tpm_timer_t tpm_step(
        input tpm_timer_t       cur,
        input logic [1:0]       mode,
        input logic             pwm,
        input logic             en,
        input logic [PSC_W-1:0] psc,
        input logic [7:0]       rl,
        input logic [7:0]       rh
    );
        tpm_timer_t  nx;     // result
        logic [7:0]  mask;   // active low_count bits
        logic        carry;  // low_count carries into high_count
        logic [16:0] wide;   // cascaded 16-bit sum
        nx     = cur;
        nx.ovf = 1'b0;
        mask   = CNT_MAX >> (3'h7 - psc);
        carry  = 1'b0;
        wide   = 17'h00000;
        if (en) begin
            unique case (mode)
                MODE_0: begin
                    nx.low = (cur.low + CNT_ONE) & mask;
                    carry  = ((cur.low & mask) == mask);
                end
                MODE_1: begin
                    if (pwm) begin
                        if (cur.low == CNT_MAX) begin
                            nx.low = rl;
                            carry  = 1'b1;
                        end else begin
                            nx.low = cur.low + CNT_ONE;
                        end
                    end else begin
                        // plain 16-bit auto reload from the hold pair
                        wide = {1'b0, cur.high, cur.low} + 17'h00001;
                        if (wide[16]) begin
                            nx.high = rh;
                            nx.low  = rl;
                            nx.ovf  = 1'b1;
                        end else begin
                            nx.high = wide[15:8];
                            nx.low  = wide[7:0];
                        end
                    end
                end
                MODE_2: begin
                    if (cur.low == CNT_MAX) begin
                        nx.low = cur.high;
                        nx.ovf = 1'b1;
                        if (pwm) begin
                            nx.pin = ~cur.pin;
                        end
                    end else begin
                        nx.low = cur.low + CNT_ONE;
                    end
                end
                MODE_3: begin
                    // handled by the caller, count holds here
                end
            endcase
            // high_count advances on the low carry
            if (carry) begin
                nx.high = cur.high + CNT_ONE;
                if (cur.high == CNT_MAX) begin
                    nx.ovf = 1'b1;
                end
            end
            if (pwm && carry && (mode == MODE_0 || mode == MODE_1)) begin
                if (nx.high == CNT_ZERO) begin
                    nx.ocr = rh;
                    nx.pin = (rh != CNT_ZERO);
                end else if (nx.high == cur.ocr) begin
                    nx.pin = 1'b0;
                end
            end
        end
        return nx;
    endfunction

    // ------------------------------------------------------------------
    // one 8-bit split channel, count in .high, compare in .ocr
    // ------------------------------------------------------------------
    function automatic tpm_timer_t tpm_chan(
        input tpm_timer_t cur,
        input logic       en,
        input logic [7:0] duty
    );
        tpm_timer_t nx;  // result
        nx     = cur;
        nx.ovf = 1'b0;
        if (en) begin
            nx.high = cur.high + CNT_ONE;
            if (cur.high == CNT_MAX) begin
                nx.ovf = 1'b1;
                nx.ocr = duty;
                // high at wrap unless zero duty
                nx.pin = (duty != CNT_ZERO);
            end else if (nx.high == cur.ocr) begin
                nx.pin = 1'b0;
            end
        end
        return nx;
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // a single combinational process computes the whole next state
    always_comb begin
        logic       tick;     // prescaled count enable
        logic       en0;      // timer 0 counting allowed
        logic       en1;      // timer 1 counting allowed
        logic       split;    // timer 0 in sub-mode 3
        logic [1:0] mode0;    // timer 0 mode bits
        logic [1:0] mode1;    // timer 1 mode bits
        logic       ev0;      // overflow0 event
        logic       ev1;      // overflow1 event
        tpm_timer_t lo;       // split low channel
        tpm_timer_t hi;       // split high channel
        tick   = 1'b0;
        en0    = 1'b0;
        en1    = 1'b0;
        split  = 1'b0;
        mode0  = timer_mode_reg_i[TIMER_MODE_REG_M0_LSB +: 2];
        mode1  = timer_mode_reg_i[TIMER_MODE_REG_M1_LSB +: 2];
        ev0    = 1'b0;
        ev1    = 1'b0;
        lo     = '0;
        hi     = '0;
        next_r = r;

        // control register write, software view of pwm enables
        if (timer_control_b_we_i) begin
            next_r.tcb = timer_control_b_wdata_i;
        end

        // shared prescaler
        // compare with >= so that lowering the divider mid-count cannot
        // send the count the long way round through 8'hFF
        tick = (r.timer_prescaler >= 8'(timer_prescaler_i));
        next_r.timer_prescaler = tick ? CNT_ZERO : (r.timer_prescaler + CNT_ONE);

        en0 = run0_i & (~timer_mode_reg_i[TIMER_MODE_REG_GATE0_BIT] | ext_irq0_pin_i);
        en1 = run1_i & (~timer_mode_reg_i[TIMER_MODE_REG_GATE1_BIT] | ext_irq1_pin_i);
        split = (mode0 == MODE_3);

        // timer 1 first: the split clears its pwm enable, which changes its count in sub-mode 1
        if (mode1 == MODE_3) begin
            // frozen as if run1 were clear
            next_r.t1     = r.t1;
            next_r.t1.ovf = 1'b0;
        end else begin
            // keeps counting for the baud tick during split
            next_r.t1 = tpm_step(r.t1, mode1, r.tcb[TCB_PWM1_BIT] & ~split,
                                 tick & en1, r.tcb[TCB_PSC1_LSB +: PSC_W],
                                 low_reload1_i, compare_hold1_i);
        end

        if (split) begin
            lo      = r.t0;
            lo.high = r.t0.low;
            lo.ocr  = r.ocr_lo;
            lo.pin  = r.pin_lo;
            hi      = r.t0;
            hi.pin  = r.pin_hi;
            // low half on timer 0 controls, high half on run1 only
            lo = tpm_chan(lo, tick & en0, low_reload0_i);
            hi = tpm_chan(hi, tick & run1_i, compare_hold0_i);
            next_r.t0.low  = lo.high;
            next_r.ocr_lo  = lo.ocr;
            next_r.pin_lo  = lo.pin;
            next_r.t0.high = hi.high;
            next_r.t0.ocr  = hi.ocr;
            next_r.pin_hi  = hi.pin;
            next_r.t0.ovf  = lo.ovf;
            ev0 = lo.ovf;
            // the high half owns overflow1 while timer 0 is split
            ev1 = hi.ovf;
        end else begin
            next_r.t0 = tpm_step(r.t0, mode0, r.tcb[TCB_PWM0_BIT], tick & en0,
                                 r.tcb[TCB_PSC0_LSB +: PSC_W],
                                 low_reload0_i, compare_hold0_i);
            ev0 = next_r.t0.ovf;
            ev1 = next_r.t1.ovf;
        end

        // sticky flags, a set beats a same-cycle clear
        next_r.ovf0 = ev0 | (r.ovf0 & ~overflow0_clr_i);
        next_r.ovf1 = ev1 | (r.ovf1 & ~overflow1_clr_i);
        // baud tick needs no interrupt, follows timer 1 overflow
        next_r.baud = next_r.t1.ovf;

        // pin driven as output, count input not sampled
        next_r.oe0  = r.tcb[TCB_PWM0_BIT];
        next_r.oe1  = r.tcb[TCB_PWM1_BIT];
        next_r.out0 = r.tcb[TCB_PWM0_BIT] & (split ? next_r.pin_lo : next_r.t0.pin);
        next_r.out1 = r.tcb[TCB_PWM1_BIT] & (split ? next_r.pin_hi : next_r.t1.pin);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // reset clears every counter; only timer_control_b has a nonzero value
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            r     <= '0;
            r.tcb <= TCB_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign timer0_pin_o      = r.out0;
    assign timer0_pin_oe_o   = r.oe0;
    assign timer1_pin_o      = r.out1;
    assign timer1_pin_oe_o   = r.oe1;
    assign overflow0_o       = r.ovf0;
    assign overflow1_o       = r.ovf1;
    assign baud_tick_o       = r.baud;
    assign timer_control_b_o = r.tcb;
    assign low_count0_o      = r.t0.low;
    assign high_count0_o     = r.t0.high;
    assign low_count1_o      = r.t1.low;
    assign high_count1_o     = r.t1.high;

endmodule // tpm_timer_pwm

// ===== test/tpm_timer_pwm_sva.sv
// port-level assertions for the timer pwm block
`timescale 1ns/10ps
module tpm_timer_pwm_sva
    import tpm_pkg::*;
(
    input wire logic       ref_clk_i,         // system clock
    input wire logic       reset_n_i,         // sync reset, active low
    input wire logic [7:0] timer_mode_reg_i,  // gate and mode bits
    input wire logic       run0_i,            // timer 0 run bit
    input wire logic       ext_irq0_pin_i,    // timer 0 gate input
    input wire logic       overflow0_clr_i,   // flag clear pulse
    input wire logic       timer0_pin_o,      // waveform
    input wire logic       timer0_pin_oe_o,   // pin drive enable
    input wire logic       overflow0_o,       // sticky flag
    input wire logic       baud_tick_o,       // timer 1 overflow pulse
    input wire logic [7:0] timer_control_b_o, // control readback
    input wire logic [7:0] low_count0_o,      // counts
    input wire logic [7:0] high_count0_o,     // counts
    input wire logic [7:0] low_count1_o,      // counts
    input wire logic [7:0] high_count1_o      // counts
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    // timer 0 low half has no count permission this cycle
    sequence s_t0_held;
        !(run0_i && (!timer_mode_reg_i[TIMER_MODE_REG_GATE0_BIT] || ext_irq0_pin_i));
    endsequence
    // timer 1 parked in its stop mode
    sequence s_t1_parked;
        timer_mode_reg_i[5:4] == MODE_3;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_reset_val;
        $rose(reset_n_i) |-> timer_control_b_o == TCB_RESET && !overflow0_o && !timer0_pin_o;
    endproperty
    property p_oe_follow;
        1 |=> timer0_pin_oe_o == $past(timer_control_b_o[TCB_PWM0_BIT]);
    endproperty
    property p_pin_off;
        !timer0_pin_oe_o |-> !timer0_pin_o;
    endproperty
    property p_flag_sticky;
        overflow0_o && !overflow0_clr_i |=> overflow0_o;
    endproperty
    // the tick shows the step taken with last cycle's mode and pwm enable;
    // plain 16-bit reload mode reloads high_count instead of wrapping to zero
    property p_baud_wrap;
        baud_tick_o && ($past(timer_mode_reg_i[5:4]) == MODE_0
            || ($past(timer_mode_reg_i[5:4]) == MODE_1
                && $past(timer_control_b_o[TCB_PWM1_BIT])
                && $past(timer_mode_reg_i[1:0]) != MODE_3))
            |-> high_count1_o == CNT_ZERO;
    endproperty
    property p_t1_freeze;
        s_t1_parked |=> $stable(low_count1_o) && $stable(high_count1_o);
    endproperty
    property p_gate_hold;
        s_t0_held |=> $stable(low_count0_o);
    endproperty
    property p_rise_wrap;
        $rose(timer0_pin_o) && timer_mode_reg_i[1] == 1'b0 && $past(timer0_pin_oe_o)
            |-> high_count0_o == CNT_ZERO;
    endproperty
    property p_toggle_reload;
        $changed(timer0_pin_o) && timer_mode_reg_i[1:0] == MODE_2 && $stable(timer_mode_reg_i)
            && $past(timer0_pin_oe_o) && timer0_pin_oe_o |-> low_count0_o == high_count0_o;
    endproperty

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_reset_val: assert property (p_reset_val)
        else $error("control readback or outputs wrong after reset");
    a_oe_follow: assert property (p_oe_follow)
        else $error("pin enable does not follow pwm enable");
    a_pin_off: assert property (p_pin_off)
        else $error("waveform high while pin not driven");
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag dropped without clear");
    a_baud_wrap: assert property (p_baud_wrap)
        else $error("baud tick without timer 1 wrap");
    a_t1_freeze: assert property (p_t1_freeze)
        else $error("timer 1 counted in stop mode");
    a_gate_hold: assert property (p_gate_hold)
        else $error("timer 0 counted without permission");
    a_rise_wrap: assert property (p_rise_wrap)
        else $error("pwm rise away from count wrap");
    a_toggle_reload: assert property (p_toggle_reload)
        else $error("toggle without low count reload");
endmodule // tpm_timer_pwm_sva

bind tpm_timer_pwm tpm_timer_pwm_sva tpm_timer_pwm_sva_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .timer_mode_reg_i(timer_mode_reg_i),
    .run0_i(run0_i), .ext_irq0_pin_i(ext_irq0_pin_i), .overflow0_clr_i(overflow0_clr_i),
    .timer0_pin_o(timer0_pin_o), .timer0_pin_oe_o(timer0_pin_oe_o), .overflow0_o(overflow0_o),
    .baud_tick_o(baud_tick_o), .timer_control_b_o(timer_control_b_o),
    .low_count0_o(low_count0_o), .high_count0_o(high_count0_o),
    .low_count1_o(low_count1_o), .high_count1_o(high_count1_o));

// ===== test/tpm_load_model.sv
// load on a pwm pin: measures pulse width and period in clocks
`timescale 1ns/10ps
module tpm_load_model (
    input  wire logic        clk_i,      // system clock
    input  wire logic        pin_i,      // driven waveform
    output logic      [15:0] high_len_o, // last complete high pulse
    output logic      [15:0] period_o,   // last rise to rise spacing
    output logic      [15:0] rises_o     // rising edges seen
);
    logic        prev    = 1'b0;   // pin one sample ago
    logic [15:0] cnt_hi  = 16'h0;  // running high length
    logic [15:0] cnt_per = 16'h0;  // running period length
    initial {high_len_o, period_o, rises_o} = 48'h0;

    // sample once a clock; the first rise reports the count since time zero as period
    always @(posedge clk_i) begin
        prev <= pin_i;
        cnt_hi <= pin_i ? cnt_hi + 16'h1 : cnt_hi;
        cnt_per <= cnt_per + 16'h1;
        if (pin_i && !prev) begin
            period_o <= cnt_per;
            cnt_per <= 16'h1;
            cnt_hi <= 16'h1;
            rises_o <= rises_o + 16'h1;
        end
        if (!pin_i && prev) begin
            high_len_o <= cnt_hi;
        end
    end
endmodule // tpm_load_model

// ===== test/tpm_timer_pwm_tb.sv
// self-checking bench of the timer pwm block
`timescale 1ns/10ps
module tpm_timer_pwm_tb;
    import tpm_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, tcb_we = 1'b0, run0 = 1'b0, run1 = 1'b0;
    logic        irq0 = 1'b0, clr0 = 1'b0;
    logic [7:0]  mode = 8'h00, tcb_wd = 8'h00, rl0 = 8'h00, rl1 = 8'h00;
    logic [7:0]  rh0 = 8'h00, rh1 = 8'h00, tcb, lc0, hc0, lc1, hc1;
    logic [3:0]  timer_prescaler = 4'h0;
    logic        p0, p1, p0_oe, p1_oe, ov0, ov1, baud;
    logic [15:0] hi [2], per [2], rises [2], v;
    int          n_mismatch = 0, tests_run = 0, c;

    always #25 clk = ~clk;  // 20 MHz

    tpm_timer_pwm #(.TPS_W(4)) tpm_timer_pwm_inst (
        .ref_clk_i(clk), .reset_n_i(rst_n), .timer_mode_reg_i(mode),
        .timer_control_b_we_i(tcb_we), .timer_control_b_wdata_i(tcb_wd),
        .timer_prescaler_i(timer_prescaler), .run0_i(run0), .run1_i(run1), .ext_irq0_pin_i(irq0),
        .ext_irq1_pin_i(1'b0), .low_reload0_i(rl0), .low_reload1_i(rl1),
        .compare_hold0_i(rh0), .compare_hold1_i(rh1), .overflow0_clr_i(clr0),
        .overflow1_clr_i(1'b0), .timer0_pin_o(p0), .timer0_pin_oe_o(p0_oe),
        .timer1_pin_o(p1), .timer1_pin_oe_o(p1_oe), .overflow0_o(ov0), .overflow1_o(ov1),
        .baud_tick_o(baud), .timer_control_b_o(tcb), .low_count0_o(lc0),
        .high_count0_o(hc0), .low_count1_o(lc1), .high_count1_o(hc1));
    tpm_load_model load0_inst (.clk_i(clk), .pin_i(p0), .high_len_o(hi[0]),
        .period_o(per[0]), .rises_o(rises[0]));
    tpm_load_model load1_inst (.clk_i(clk), .pin_i(p1), .high_len_o(hi[1]),
        .period_o(per[1]), .rises_o(rises[1]));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_tcb(input logic [7:0] d);
        @(negedge clk);
        tcb_we = 1'b1;
        tcb_wd = d;
        @(negedge clk);
        tcb_we = 1'b0;
    endtask
    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
    endtask
    // bounded wait for n more rising edges on pin s
    task automatic wait_rises(input int s, input int n);
        logic [15:0] goal;
        int          lim;
        goal = rises[s] + 16'(n);
        lim = 0;
        while (rises[s] !== goal && lim < 8000) begin
            @(negedge clk);
            lim++;
        end
        if (lim >= 8000) begin
            check(rises[s], goal);
            end_of_test();
        end
    endtask
    // count cycles with baud tick (w=0) or pin 0 high (w=1)
    task automatic count_cyc(input int n, input int w, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(negedge clk);
            cnt += int'(w ? p0 : baud);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(tcb, 16'h0024);
        check({p0, ov0, ov1, baud}, 16'h0);
        // counter_timer_select bits kept at internal clocking
        // software setup
        mode = 8'h00;
        rh0 = 8'h40;
        run0 = 1'b1;
        // log prescaler widths and shared divider
        for (int i = 0; i < 3; i++) begin
            wr_tcb({1'b0, 1'b1, 3'h4, 2'h0, i[0]});
            timer_prescaler = {3'h0, i[1]};
            wait_rises(0, 3);
            check(hi[0], 16'h0080 << (i[0] + i[1]));
            check(per[0], 16'h0200 << (i[0] + i[1]));
        end
        timer_prescaler = 4'h0;
        wait_rises(0, 1);
        rh0 = 8'h20;
        wait_rises(0, 1);
        check(hi[0], 16'h0080);
        wait_rises(0, 1);
        check(hi[0], 16'h0040);
        check(ov0, 16'h1);
        clr0 = 1'b1;
        @(negedge clk);
        clr0 = 1'b0;
        check(ov0, 16'h0);
        rh0 = 8'h00;
        count_cyc(600, 1, c);
        count_cyc(1100, 1, c);
        check(16'(c), 16'h0);
        // gate closes counting until the pin goes high
        mode = 8'h08;
        @(negedge clk);
        // low_count0 is one bit wide here, so watch both halves
        v = {hc0, lc0};
        count_cyc(20, 0, c);
        check({hc0, lc0}, v);
        irq0 = 1'b1;
        repeat (2) @(negedge clk);
        check(16'({hc0, lc0} != v), 16'h1);
        // timer 1 linear prescaler, then parked
        mode = 8'h10;
        rl1 = 8'hFE;
        rh1 = 8'h80;
        run1 = 1'b1;
        wr_tcb(8'hA4);
        wait_rises(1, 3);
        check(hi[1], 16'h0100);
        check(per[1], 16'h0200);
        check({p0_oe, p1_oe}, 16'h1);
        count_cyc(512, 0, c);
        check(16'(c), 16'h1);
        mode = 8'h30;
        @(negedge clk);
        v = {hc1, lc1};
        count_cyc(512, 0, c);
        check(16'(c), 16'h0);
        check({hc1, lc1}, v);
        // frequency generator, hold and reload used as scratch
        do_reset();
        check(tcb, 16'h0024);
        mode = 8'h02;
        rh0 = 8'hAB;
        rl0 = 8'hCD;
        wr_tcb(8'h64);
        wait_rises(0, 3);
        check(hi[0], 16'h0100);
        check(per[0], 16'h0200);
        // split mode, timer 1 as baud source on and off
        do_reset();
        mode = 8'h23;
        rl0 = 8'h40;
        rh0 = 8'hC0;
        wr_tcb(8'hE4);
        wait_rises(0, 3);
        check(hi[0], 16'h0040);
        check(per[0], 16'h0100);
        wait_rises(1, 3);
        check(hi[1], 16'h00C0);
        check(per[1], 16'h0100);
        check(ov1, 16'h1);
        count_cyc(512, 0, c);
        check(16'(c), 16'h2);
        mode = 8'h33;
        @(negedge clk);
        count_cyc(512, 0, c);
        check(16'(c), 16'h0);
        end_of_test();
    end
endmodule // tpm_timer_pwm_tb
